// *** rtc_supply_monitor_fout_trim_cfg.sv ***
/*
 configuration and monitor logic: frequency output select, brownout trip
 select and low-supply flag, battery trip selects and flags, battery
 disconnect, timestamp clear pulse and read-only crystal trim.
 assumes comparator levels and supply mode arrive asynchronously, and a
 byte register port with one-cycle write strobe; read data is registered and
 shows the addressed register one cycle after the address.
*/
`timescale 1ns/1ps
module rtc_supply_monitor_fout_trim_cfg #(
   parameter logic [7:0] preset_trim = 8'h20
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   input wire logic supply_mode_i,
   input wire logic supply_below_i,
   input wire logic batt_first_below_i,
   input wire logic batt_second_below_i,
   input wire logic seconds_tick_i,
   input wire logic [5:0] seconds_i,
   input wire logic alarm_n_i,
   output logic irq_freq_pin_oe_o,
   output logic low_supply_flag_o,
   output logic batt_first_low_flag_o,
   output logic batt_second_low_flag_o,
   output logic clear_timestamps_o,
   output logic battery_disconnect_o,
   output logic [2:0] brownout_trip_sel_o,
   output logic [2:0] batt_first_alarm_sel_o,
   output logic [2:0] batt_second_alarm_sel_o,
   output logic [5:0] analog_trim_field_o,
   output logic [1:0] coarse_digital_trim_o
);
   logic [3:0] freq_out_select_q;
   logic [2:0] brownout_q;
   logic [2:0] first_q;
   logic [2:0] second_q;
   logic disconnect_q;
   logic [7:0] trim_q;
   logic [1:0] mode_s;
   logic [1:0] below_s;
   logic [1:0] first_s;
   logic [1:0] second_s;
   logic wave;
   logic on_supply;
   logic on_supply_q;
   logic check;
   logic wr_freq, wr_supply, wr_batt;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction

   assign wr_freq = wr_i && hit(addr_i, rtc_cfg_pkg::freq_ctrl_addr);
   assign wr_supply = wr_i && hit(addr_i, rtc_cfg_pkg::supply_brownout_control_addr);
   assign wr_batt = wr_i && hit(addr_i, rtc_cfg_pkg::battery_trip_control_addr);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         mode_s <= 2'h0;
         below_s <= 2'h0;
         first_s <= 2'h0;
         second_s <= 2'h0;
      end
      else
      begin
         mode_s <= {mode_s[0], supply_mode_i};
         below_s <= {below_s[0], supply_below_i};
         first_s <= {first_s[0], batt_first_below_i};
         second_s <= {second_s[0], batt_second_below_i};
      end
   end

   assign on_supply = mode_s[1];

   ////////////////////////////////////////////////////////////////////////
   // output select
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         freq_out_select_q <= rtc_cfg_pkg::freq_sel_reset;
      else if (wr_freq)
         freq_out_select_q <= wdata_i[rtc_cfg_pkg::freq_sel_lsb +: 4];
   end

   freq_divider u_div (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .sel_i(freq_out_select_q),
      .wave_o(wave)
   );

   // open drain: pull low while wave low, else alarm drives
   always_comb
   begin
      if (freq_out_select_q != 4'h0)
         irq_freq_pin_oe_o = !wave;
      else
         irq_freq_pin_oe_o = !alarm_n_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // supply control: trip select and timestamp clear pulse
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         brownout_q <= rtc_cfg_pkg::brownout_reset;
      else if (wr_supply && wdata_i[rtc_cfg_pkg::brownout_lsb +: 3] <= rtc_cfg_pkg::brownout_last_code)
         brownout_q <= wdata_i[rtc_cfg_pkg::brownout_lsb +: 3];
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         clear_timestamps_o <= 1'b0;
      else
         clear_timestamps_o <= wr_supply && wdata_i[rtc_cfg_pkg::clear_stamp_bit];
   end

   // real-time brownout flag, only while on main supply
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         low_supply_flag_o <= 1'b0;
      else
         low_supply_flag_o <= on_supply && below_s[1];
   end

   ////////////////////////////////////////////////////////////////////////
   // battery trip selects
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         first_q <= rtc_cfg_pkg::first_alarm_reset;
         second_q <= rtc_cfg_pkg::second_alarm_reset;
      end
      else if (wr_batt)
      begin
         if (wdata_i[rtc_cfg_pkg::first_alarm_lsb +: 3] <= rtc_cfg_pkg::batt_last_code)
            first_q <= wdata_i[rtc_cfg_pkg::first_alarm_lsb +: 3];
         if (wdata_i[rtc_cfg_pkg::second_alarm_lsb +: 3] <= rtc_cfg_pkg::batt_last_code)
            second_q <= wdata_i[rtc_cfg_pkg::second_alarm_lsb +: 3];
      end
   end

   // disconnect: set by write, cleared when supply returns after a drop
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         on_supply_q <= 1'b0;
      else
         on_supply_q <= on_supply;
   end

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         disconnect_q <= 1'b0;
      else if (wr_batt && wdata_i[rtc_cfg_pkg::disconnect_bit])
         disconnect_q <= 1'b1;
      else if (on_supply && !on_supply_q)
         disconnect_q <= 1'b0;
   end

   // once-a-minute battery check on main supply
   assign check = on_supply && seconds_tick_i && (seconds_i == rtc_cfg_pkg::seconds_compare);

   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
      begin
         batt_first_low_flag_o <= 1'b0;
         batt_second_low_flag_o <= 1'b0;
      end
      else if (check)
      begin
         batt_first_low_flag_o <= first_s[1];
         batt_second_low_flag_o <= second_s[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trim: cleared at reset, preset loaded from the first cycle after, never written by the host
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         trim_q <= 8'h00;
      else
         trim_q <= preset_trim;
   end

   assign analog_trim_field_o = trim_q[rtc_cfg_pkg::analog_trim_lsb +: 6];
   assign coarse_digital_trim_o = trim_q[rtc_cfg_pkg::digital_trim_lsb +: 2];
   assign battery_disconnect_o = disconnect_q;
   assign brownout_trip_sel_o = brownout_q;
   assign batt_first_alarm_sel_o = first_q;
   assign batt_second_alarm_sel_o = second_q;

   ////////////////////////////////////////////////////////////////////////
   // registered read mux
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         rdata_o <= 8'h00;
      else if (hit(addr_i, rtc_cfg_pkg::freq_ctrl_addr))
         rdata_o <= {4'h0, freq_out_select_q};
      else if (hit(addr_i, rtc_cfg_pkg::supply_brownout_control_addr))
         rdata_o <= {5'h00, brownout_q};
      else if (hit(addr_i, rtc_cfg_pkg::battery_trip_control_addr))
         rdata_o <= {1'b0, disconnect_q, first_q, second_q};
      else if (hit(addr_i, rtc_cfg_pkg::initial_crystal_trim_addr))
         rdata_o <= trim_q;
      else
         rdata_o <= 8'h00;
   end
endmodule

// *** rtc_cfg_pkg.sv ***
/*
 holds register offsets, field positions, reset values and encodings of the
 supply/battery monitor, frequency output and crystal trim configuration.
 assumes a single 250 mhz clock domain and a byte-wide register port.
*/
// What this block does
// - four-bit output select; zero off, codes one to fifteen pick 32768 Hz down to 1/32 Hz
// - output select resets to one, full oscillator frequency on the pin
// - nonzero output select overrides alarm signalling on the shared pin
// - writing one to clear bit wipes both switchover timestamps; defaults zero
// - three-bit brownout field picks 2.295 to 4.675 volt threshold
// - supply below chosen threshold sets the low-supply flag
// - battery trip register holds first and second alarm threshold selects
// - writing one to disconnect bit starts battery pin disconnect
// - after supply power cycle disconnect bit clears and battery reconnects
// - first-alarm field codes zero to six give 2.125 to 4.675 volts
// - second-alarm field codes zero to six give 1.875 to 4.125 volts
// - trim values load from preset storage at power-up; host writes ignored
// - correction uses digital pulse skip/insert plus analog load capacitance trim
// - coarse digital trim decodes 00 off, 01 plus, 10 zero, 11 minus 30.5 ppm
// - low-supply flag self-clears above trip level; detection only on main supply
// - on main supply both battery comparisons run when seconds reach 59
package rtc_cfg_pkg;
   localparam logic [7:0] freq_ctrl_addr = 8'h08;
   localparam logic [7:0] supply_brownout_control_addr = 8'h09;
   localparam logic [7:0] battery_trip_control_addr = 8'h0a;
   localparam logic [7:0] initial_crystal_trim_addr = 8'h0b;
   localparam int freq_sel_lsb = 0;
   localparam int clear_stamp_bit = 7;
   localparam int brownout_lsb = 0;
   localparam int disconnect_bit = 6;
   localparam int first_alarm_lsb = 3;
   localparam int second_alarm_lsb = 0;
   localparam int analog_trim_lsb = 0;
   localparam int digital_trim_lsb = 6;
   localparam logic [3:0] freq_sel_reset = 4'h1;
   localparam logic [2:0] brownout_reset = 3'h0;
   localparam logic [2:0] first_alarm_reset = 3'h0;
   localparam logic [2:0] second_alarm_reset = 3'h0;
   localparam logic [2:0] brownout_last_code = 3'h5;
   localparam logic [2:0] batt_last_code = 3'h6;
   localparam logic [5:0] seconds_compare = 6'h3b;
   localparam int osc_hz = 32768;
   localparam int clk_mhz = 250;
   localparam int clk_hz = clk_mhz * 1000000;
   // half period of the 32768 hz base tone, in 4 ns cycles, rounded down
   localparam int base_half_cycles = clk_hz / (2 * osc_hz);
   typedef enum logic [1:0] {trim_off, trim_plus, trim_zero, trim_minus} coarse_trim_t;
endpackage

// *** freq_divider.sv ***
/*
 divider that builds the selectable square wave for the shared pin.
 builds its own tick at twice 32768 hz from the system clock with a prescaler.
*/
`timescale 1ns/1ps
module freq_divider #(
   parameter int half_cycles = rtc_cfg_pkg::base_half_cycles
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [3:0] sel_i,
   output logic wave_o
);
   // prescaler is sixteen bits wide
   if (half_cycles < 1 || half_cycles > 65536)
   begin : g_bad_half
      $error("half_cycles must lie between 1 and 65536");
   end

   logic [15:0] pre_q;
   logic tick;
   logic [20:0] div_q;

   assign tick = (pre_q == 16'(half_cycles - 1));

   ////////////////////////////////////////////////////////////////////////
   // base tick at twice 32768 hz
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i || tick)
         pre_q <= 16'h0000;
      else
         pre_q <= pre_q + 16'h0001;
   end

   // binary ripple of the base tone, bit n halves n times
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         div_q <= 21'h000000;
      else if (tick)
         div_q <= div_q + 21'h000001;
   end

   ////////////////////////////////////////////////////////////////////////
   // selection tap per code
   always_ff @(posedge clock_i)
   begin
      if (!nrst_i)
         wave_o <= 1'b0;
      else
      begin
         unique case (sel_i)
            4'h0: wave_o <= 1'b0;
            4'h1: wave_o <= div_q[0];
            4'h2: wave_o <= div_q[3];
            4'h3: wave_o <= div_q[5];
            4'h4: wave_o <= div_q[9];
            4'h5: wave_o <= div_q[10];
            4'h6: wave_o <= div_q[11];
            4'h7: wave_o <= div_q[12];
            4'h8: wave_o <= div_q[13];
            4'h9: wave_o <= div_q[14];
            4'ha: wave_o <= div_q[15];
            4'hb: wave_o <= div_q[16];
            4'hc: wave_o <= div_q[17];
            4'hd: wave_o <= div_q[18];
            4'he: wave_o <= div_q[19];
            4'hf: wave_o <= div_q[20];
         endcase
      end
   end
endmodule

// *** host_model.sv ***
/* host model driving the byte register port.
 assumes read data registered one cycle after the address and a write taken at a rising edge. */
`timescale 1ns/1ps
module host_model (
   input wire logic clock_i,
   input wire logic [7:0] rdata_i,
   output logic [7:0] addr_o,
   output logic wr_o,
   output logic [7:0] wdata_o
);
   initial
   begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      wdata_o = 8'h5a;
   end
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      #1;
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge clock_i);
      #1;
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      #1;
      addr_o = a;
      @(posedge clock_i);
      #1;
      d = rdata_i;
   endtask
endmodule

// *** rtc_cfg_checker.sv ***
/* checker on the cfg block ports.
 assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module rtc_cfg_checker (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   input wire logic supply_mode_i,
   input wire logic supply_below_i,
   input wire logic batt_first_below_i,
   input wire logic seconds_tick_i,
   input wire logic [5:0] seconds_i,
   input wire logic alarm_n_i,
   input wire logic irq_freq_pin_oe_o,
   input wire logic low_supply_flag_o,
   input wire logic batt_first_low_flag_o,
   input wire logic clear_timestamps_o,
   input wire logic battery_disconnect_o,
   input wire logic [2:0] brownout_trip_sel_o,
   input wire logic [5:0] analog_trim_field_o,
   input wire logic [1:0] coarse_digital_trim_o
);
   wire w9 = wr_i && addr_i == 8'h09;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   a_clear_pulse: assert property (clear_timestamps_o == $past(w9 && wdata_i[7]))
      else $error("clear pulse wrong");
   a_brown_load: assert property (w9 && wdata_i[2:0] <= 3'h5 |=> brownout_trip_sel_o == $past(wdata_i[2:0]))
      else $error("brownout code not taken");
   a_brown_keep: assert property (w9 && wdata_i[2:0] > 3'h5 |=> $stable(brownout_trip_sel_o))
      else $error("reserved brownout code taken");
   a_trim_fixed: assert property (wr_i && addr_i == 8'h0b |=> $stable({coarse_digital_trim_o, analog_trim_field_o}))
      else $error("trim changed by write");
   a_disc_set: assert property (wr_i && addr_i == 8'h0a && wdata_i[6] |=> battery_disconnect_o)
      else $error("disconnect not set");
   a_pin_alarm: assert property ($past(addr_i == 8'h08 && !wr_i) && rdata_o[3:0] == 4'h0
      |-> irq_freq_pin_oe_o == !alarm_n_i)
      else $error("pin not following alarm");
   a_low_set: assert property ((supply_mode_i && supply_below_i) [*5] |-> low_supply_flag_o)
      else $error("low supply flag not set");
   a_low_clear: assert property ((supply_mode_i && !supply_below_i) [*5] |-> !low_supply_flag_o)
      else $error("low supply flag stuck");
   a_batt_check: assert property ((supply_mode_i && batt_first_below_i) [*4] ##0
      (seconds_tick_i && seconds_i == 6'h3b) |=> ##[0:2] batt_first_low_flag_o)
      else $error("battery flag not set at check");
endmodule

// *** tb.sv ***
/* self-checking bench of the cfg block.
 assumes the host model and checker files compile first. */
`timescale 1ns/1ps
module tb;
   logic clock_i, nrst_i, wr_i, mode, below, b1, b2, tick, alarm_n;
   logic oe, low, bf1, bf2, clr, disc;
   logic [7:0] addr, wdata, rdata, d, e;
   logic [5:0] sec, atrim;
   logic [1:0] ctrim;
   logic [2:0] brown, f1, f2;
   int bad_count = 0;
   int tests_run = 0;
   int cnt;
   localparam logic [7:0] preset = 8'h9c; // arbitrary
   rtc_supply_monitor_fout_trim_cfg #(.preset_trim(preset)) u_rtc_supply_monitor_fout_trim_cfg (
      .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wr_i(wr_i), .wdata_i(wdata), .rdata_o(rdata),
      .supply_mode_i(mode), .supply_below_i(below), .batt_first_below_i(b1), .batt_second_below_i(b2),
      .seconds_tick_i(tick), .seconds_i(sec), .alarm_n_i(alarm_n), .irq_freq_pin_oe_o(oe),
      .low_supply_flag_o(low), .batt_first_low_flag_o(bf1), .batt_second_low_flag_o(bf2),
      .clear_timestamps_o(clr), .battery_disconnect_o(disc), .brownout_trip_sel_o(brown),
      .batt_first_alarm_sel_o(f1), .batt_second_alarm_sel_o(f2), .analog_trim_field_o(atrim),
      .coarse_digital_trim_o(ctrim));
   host_model u_host_model (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr_i), .wdata_o(wdata));
   initial
   begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      u_host_model.read(a, d);
      chk(d, exp);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic pulse(input logic [5:0] s);
      sec = s;
      tick = 1'b1;
      wait_n(1);
      tick = 1'b0;
      wait_n(2);
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic t_reset;
      rd(8'h08, 8'h01);
      rd(8'h0b, preset);
      $display("reset value test done");
   endtask
   task automatic t_freq;
      for (int i = 0; i < 16; i++)
      begin
         u_host_model.write(8'h08, 8'(i));
         rd(8'h08, 8'(i));
      end
      u_host_model.write(8'h08, 8'h00);
      wait_n(1);
      alarm_n = 1'b0;
      #1 chk(8'(oe), 8'h01);
      u_host_model.write(8'h08, 8'h01);
      cnt = 0;
      repeat (8000)
      begin
         wait_n(1);
         cnt += int'(oe === 1'b0);
      end
      chk(8'(cnt > 3000 && cnt < 5000), 8'h01);
      alarm_n = 1'b1;
      $display("frequency output test done");
   endtask
   task automatic t_regs;
      e = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         u_host_model.write(8'h09, 8'(i));
         if (i <= 5) e = 8'(i);
         rd(8'h09, e);
      end
      u_host_model.write(8'h09, 8'h83);
      chk(8'(clr), 8'h01);
      rd(8'h09, 8'h03);
      chk(8'(clr), 8'h00);
      e = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         u_host_model.write(8'h0a, {2'b00, 3'(i), 3'(i)});
         if (i <= 6) e = {2'b00, 3'(i), 3'(i)};
         rd(8'h0a, e);
      end
      chk({2'b00, f1, f2}, e);
      u_host_model.write(8'h0a, 8'h40 | e);
      chk(8'(disc), 8'h01);
      mode = 1'b0;
      wait_n(6);
      mode = 1'b1;
      wait_n(6);
      chk(8'(disc), 8'h00);
      $display("register test done");
   endtask
   task automatic t_mon;
      below = 1'b1;
      wait_n(5);
      chk(8'(low), 8'h01);
      below = 1'b0;
      wait_n(5);
      chk(8'(low), 8'h00);
      b1 = 1'b1;
      wait_n(6);
      pulse(6'h3a);
      chk(8'(bf1), 8'h00);
      pulse(6'h3b);
      chk({bf1, bf2}, 8'h02);
      b1 = 1'b0;
      b2 = 1'b1;
      wait_n(6);
      pulse(6'h3b);
      chk(8'({bf1, bf2}), 8'h01);
      b2 = 1'b0;
      u_host_model.write(8'h0b, ~preset);
      u_host_model.write(8'h3f, 8'hff);
      rd(8'h0b, preset);
      chk(8'(atrim), 8'(preset[5:0]));
      chk(8'(ctrim), 8'(preset[7:6]));
      rd(8'h08, 8'h01);
      $display("monitor and trim test done");
   endtask
   initial
   begin
      nrst_i = 1'b0;
      mode = 1'b1;
      below = 1'b0;
      b1 = 1'b0;
      b2 = 1'b0;
      tick = 1'b0;
      sec = 6'h00;
      alarm_n = 1'b1;
      wait_n(20);
      nrst_i = 1'b1;
      wait_n(4);
      t_reset;
      t_freq;
      t_regs;
      t_mon;
      results;
   end
   initial
   begin
      #160000;
      bad_count++;
      results;
   end
endmodule
bind rtc_supply_monitor_fout_trim_cfg rtc_cfg_checker u_chk (.*);
